// ===== core/ast_map.svh
`ifndef AST_MAP_SVH
`define AST_MAP_SVH
// register byte offsets
`define AST_OFF_MODE 8'h00
`define AST_OFF_BAUD 8'h04
`define AST_OFF_CTRL 8'h08
`define AST_OFF_TXBUF 8'h0C
`define AST_OFF_RXBUF 8'h10
`define AST_OFF_STAT 8'h14
// mode register fields
`define AST_MODE_SEL_LSB 0
`define AST_MODE_STOP2 4
`define AST_MODE_PEVEN 5
`define AST_MODE_PEN 6
// control register fields
`define AST_CTRL_SRC_LSB 0
`define AST_CTRL_TXEN 4
`define AST_CTRL_RXEN 5
// receive buffer fields
`define AST_RX_OVR 12
`define AST_RX_FRM 13
`define AST_RX_PAR 14
`define AST_RX_SUM 15
// reset values
`define AST_RST_MODE 7'h00
`define AST_RST_BAUD 8'h00
`define AST_RST_CTRL 2'h0
// timing counts
`define AST_OVERSAMPLE 16
`define AST_PRE_MID 8
`define AST_PRE_SLOW 32
`endif

// ===== core/ast_pkg.sv
package ast_pkg;
  typedef enum logic [1:0] {
    AST_LEN_OFF, AST_LEN_7, AST_LEN_8, AST_LEN_9
  } ast_len_t;
  typedef enum logic [1:0] {
    AST_SRC_DIV1, AST_SRC_DIV8, AST_SRC_DIV32, AST_SRC_EXT
  } ast_src_t;
  typedef enum logic [2:0] {
    AST_IDLE, AST_LEAD, AST_DATA, AST_CHK, AST_END
  } ast_state_t;
endpackage

// ===== core/ast_uart.sv
// What this block does
// RULE_01: transmit and receive paths run independently
// RULE_02: seven, eight or nine bits, parity, stops
// RULE_03: one low lead bit before character bits
// RULE_04: sent bits are last transmit buffer write
// RULE_05: check bit gives even or odd ones
// RULE_06: one or two high end bits close frame
// RULE_07: bit rate is divider output over sixteen
// RULE_08: count source: three taps or external pin
// RULE_09: taps are main clock over 1, 8, 32
// RULE_10: divider divides source by value plus one
// RULE_11: overrun when unread buffer gets new character
// RULE_12: overrun still overwrites the receive buffer
// RULE_13: overrun gives no new receive request
// RULE_14: framing error when end bit sampled low
// RULE_15: parity error on ones count mismatch
// RULE_16: errors flagged at buffer transfer
// RULE_17: error sum is OR of three flags
// RULE_18: mode off or receive disable clears flags; mode off here clears only overrun and framing, not parity
// RULE_19: receive buffer read clears parity flag
// RULE_20: receive disable then enable reinitialises buffer
// RULE_21: software reads flags with character together
// RULE_22: resend by writing the transmit buffer again
// RULE_23: receiver finds lead edge, samples bit centre
`timescale 1ns/1ps
`include "ast_map.svh"
`default_nettype none
module ast_uart (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  // serial line and external count source
  input wire logic rxd,
  output logic txd,
  input wire logic ext_clk,
  // events
  output logic rx_req,
  output logic tx_empty
);
  logic [6:0] mode_ff;
  logic [7:0] baud_ff;
  logic [1:0] src_ff;
  logic tx_en_ff;
  logic rx_en_ff;
  logic [15:0] rdata_ff;

  // register decode
  wire wr_mode = reg_wr && reg_addr == `AST_OFF_MODE;
  wire wr_baud = reg_wr && reg_addr == `AST_OFF_BAUD;
  wire wr_ctrl = reg_wr && reg_addr == `AST_OFF_CTRL;
  wire wr_txb = reg_wr && reg_addr == `AST_OFF_TXBUF;
  wire rd_rxb = reg_rd && reg_addr == `AST_OFF_RXBUF;

  ast_pkg::ast_len_t len;
  assign len = ast_pkg::ast_len_t'(mode_ff[1:0]);
  wire enabled = len != ast_pkg::AST_LEN_OFF;
  wire stop2 = mode_ff[`AST_MODE_STOP2];
  wire peven = mode_ff[`AST_MODE_PEVEN];
  wire pen = mode_ff[`AST_MODE_PEN];
  // data bits minus one: 6, 7 or 8
  wire [3:0] last_bit = len == ast_pkg::AST_LEN_9 ? 4'h8 :
                        len == ast_pkg::AST_LEN_8 ? 4'h7 : 4'h6;
  wire [8:0] len_mask = len == ast_pkg::AST_LEN_9 ? 9'h1FF :
                        len == ast_pkg::AST_LEN_8 ? 9'h0FF : 9'h07F;

  // writing a disabled mode clears overrun and framing
  wire mode_off_wr = wr_mode &&
    reg_wdata[1:0] == 2'(ast_pkg::AST_LEN_OFF); // [RULE_18]
  wire nxt_rx_en = wr_ctrl ? reg_wdata[`AST_CTRL_RXEN] : rx_en_ff;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      mode_ff <= `AST_RST_MODE;
      baud_ff <= `AST_RST_BAUD;
      src_ff <= `AST_RST_CTRL;
      tx_en_ff <= 1'b0;
      rx_en_ff <= 1'b0;
    end else begin
      if (wr_mode) mode_ff <= reg_wdata[6:0]; // [RULE_02]
      if (wr_baud) baud_ff <= reg_wdata[7:0];
      if (wr_ctrl) begin
        src_ff <= reg_wdata[1:0];
        tx_en_ff <= reg_wdata[`AST_CTRL_TXEN];
      end
      rx_en_ff <= nxt_rx_en;
    end
  end

  // free-running prescaler: the first bit of a frame may come up
  // short by up to one oversample tick, the price of sharing one divider
  // count source: prescaler taps or external pin edge
  logic [4:0] pre_ff;
  logic ext_ff;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pre_ff <= 5'h00;
      ext_ff <= 1'b0;
    end else begin
      pre_ff <= pre_ff + 5'h01;
      ext_ff <= ext_clk;
    end
  end
  wire tap8 = pre_ff[2:0] == 3'(`AST_PRE_MID - 1); // [RULE_09]
  wire tap32 = pre_ff == 5'(`AST_PRE_SLOW - 1); // [RULE_09]
  wire ext_rise = ext_clk && !ext_ff;
  logic src_tick;
  always_comb begin
    case (ast_pkg::ast_src_t'(src_ff)) // [RULE_08]
      ast_pkg::AST_SRC_DIV1: src_tick = 1'b1;
      ast_pkg::AST_SRC_DIV8: src_tick = tap8;
      ast_pkg::AST_SRC_DIV32: src_tick = tap32;
      ast_pkg::AST_SRC_EXT: src_tick = ext_rise;
      default: src_tick = 1'b0;
    endcase
  end

  // baud divider: one tick every (n+1) source ticks
  // a zero divider value gives one oversample tick per source tick
  logic [7:0] bdiv_ff;
  always_ff @(posedge clk) begin
    if (!rst_n || !enabled) bdiv_ff <= 8'h00;
    else if (src_tick)
      bdiv_ff <= bdiv_ff == 8'h00 ? baud_ff : bdiv_ff - 8'h01; // [RULE_10]
  end
  // sixteen of these make one bit time
  wire os_tick = src_tick && bdiv_ff == 8'h00 && enabled;
  localparam logic [3:0] OS_LAST = 4'(`AST_OVERSAMPLE - 1);
  localparam logic [3:0] OS_MID = 4'(`AST_OVERSAMPLE / 2 - 1);

  // transmitter, independent of the receiver
  // one-deep transmit buffer: a write during a frame waits its turn
  ast_pkg::ast_state_t tx_st_ff;
  logic [8:0] txbuf_ff;
  logic tx_full_ff;
  logic [8:0] tx_sh_ff;
  logic [3:0] tx_os_ff;
  logic [3:0] tx_cnt_ff;
  logic tx_par_ff;
  logic txd_ff;
  wire tx_bit_end = os_tick && tx_os_ff == OS_LAST; // [RULE_07]
  wire tx_go = tx_st_ff == ast_pkg::AST_IDLE && tx_full_ff &&
               tx_en_ff && enabled;
  wire [8:0] tx_data = txbuf_ff & len_mask;
  wire tx_par = peven ? ^tx_data : ~^tx_data; // [RULE_05]

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      txbuf_ff <= 9'h000;
      tx_full_ff <= 1'b0;
    end else begin
      if (wr_txb) txbuf_ff <= reg_wdata[8:0]; // [RULE_04]
      // a write beside the load keeps the buffer full
      if (wr_txb) tx_full_ff <= 1'b1; // [RULE_22]
      else if (tx_go || !enabled) tx_full_ff <= 1'b0;
    end
  end

  ast_pkg::ast_state_t nxt_tx_st;
  always_comb begin
    nxt_tx_st = tx_st_ff;
    case (tx_st_ff)
      ast_pkg::AST_IDLE:
        if (tx_go) nxt_tx_st = ast_pkg::AST_LEAD; // [RULE_03]
      ast_pkg::AST_LEAD:
        if (tx_bit_end) nxt_tx_st = ast_pkg::AST_DATA;
      ast_pkg::AST_DATA:
        if (tx_bit_end && tx_cnt_ff == last_bit)
          nxt_tx_st = pen ? ast_pkg::AST_CHK : ast_pkg::AST_END;
      ast_pkg::AST_CHK:
        if (tx_bit_end) nxt_tx_st = ast_pkg::AST_END;
      ast_pkg::AST_END:
        if (tx_bit_end && (!stop2 || tx_cnt_ff == 4'h1))
          nxt_tx_st = ast_pkg::AST_IDLE; // [RULE_06]
      default: nxt_tx_st = ast_pkg::AST_IDLE;
    endcase
    if (!enabled) nxt_tx_st = ast_pkg::AST_IDLE;
  end

  wire tx_state_chg = nxt_tx_st != tx_st_ff;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      tx_st_ff <= ast_pkg::AST_IDLE;
      tx_sh_ff <= 9'h000;
      tx_os_ff <= 4'h0;
      tx_cnt_ff <= 4'h0;
      tx_par_ff <= 1'b0;
    end else begin
      tx_st_ff <= nxt_tx_st;
      if (tx_go) begin
        tx_sh_ff <= tx_data;
        tx_par_ff <= tx_par;
        tx_os_ff <= 4'h0;
      end else if (os_tick) begin
        tx_os_ff <= tx_os_ff + 4'h1;
      end
      if (tx_state_chg) tx_cnt_ff <= 4'h0;
      else if (tx_bit_end) tx_cnt_ff <= tx_cnt_ff + 4'h1;
      if (tx_bit_end && tx_st_ff == ast_pkg::AST_DATA)
        tx_sh_ff <= {1'b0, tx_sh_ff[8:1]}; // lsb first
    end
  end

  logic nxt_txd;
  always_comb begin
    case (tx_st_ff)
      ast_pkg::AST_LEAD: nxt_txd = 1'b0; // [RULE_03]
      ast_pkg::AST_DATA: nxt_txd = tx_sh_ff[0]; // [RULE_04]
      ast_pkg::AST_CHK: nxt_txd = tx_par_ff; // [RULE_05]
      default: nxt_txd = 1'b1; // [RULE_06]
    endcase
  end
  // registered so the line never glitches between bits
  always_ff @(posedge clk) begin
    if (!rst_n) txd_ff <= 1'b1;
    else txd_ff <= nxt_txd;
  end

  // receiver
  // the lead bit is checked at its centre; later bits are sampled
  // sixteen ticks apart, near the middle of each bit
  ast_pkg::ast_state_t rx_st_ff;
  logic [8:0] rx_sh_ff;
  logic [3:0] rx_os_ff;
  logic [3:0] rx_cnt_ff;
  logic rx_pbit_ff;
  logic rx_fe_ff;
  logic rxd_prev_ff;
  logic [8:0] rxbuf_ff;
  logic rx_full_ff;
  logic ovr_ff;
  logic frm_ff;
  logic par_ff;
  logic rx_req_ff;
  wire rx_on = rx_en_ff && enabled;
  wire rx_fall = rxd_prev_ff && !rxd; // [RULE_23]
  wire rx_mid = os_tick && rx_os_ff == OS_MID; // [RULE_23]
  wire rx_samp = os_tick && rx_os_ff == OS_LAST;
  wire rx_last_end = !stop2 || rx_cnt_ff == 4'h1;
  wire rx_done = rx_st_ff == ast_pkg::AST_END && rx_samp && rx_last_end;

  ast_pkg::ast_state_t nxt_rx_st;
  always_comb begin
    nxt_rx_st = rx_st_ff;
    case (rx_st_ff)
      ast_pkg::AST_IDLE:
        if (rx_fall) nxt_rx_st = ast_pkg::AST_LEAD;
      ast_pkg::AST_LEAD:
        // a lead bit gone high at its centre was a glitch
        if (rx_mid)
          nxt_rx_st = rxd ? ast_pkg::AST_IDLE : ast_pkg::AST_DATA;
      ast_pkg::AST_DATA:
        if (rx_samp && rx_cnt_ff == last_bit)
          nxt_rx_st = pen ? ast_pkg::AST_CHK : ast_pkg::AST_END;
      ast_pkg::AST_CHK:
        if (rx_samp) nxt_rx_st = ast_pkg::AST_END;
      ast_pkg::AST_END:
        if (rx_done) nxt_rx_st = ast_pkg::AST_IDLE;
      default: nxt_rx_st = ast_pkg::AST_IDLE;
    endcase
    if (!rx_on) nxt_rx_st = ast_pkg::AST_IDLE;
  end

  wire rx_state_chg = nxt_rx_st != rx_st_ff;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rx_st_ff <= ast_pkg::AST_IDLE;
      rx_sh_ff <= 9'h000;
      rx_os_ff <= 4'h0;
      rx_cnt_ff <= 4'h0;
      rx_pbit_ff <= 1'b0;
      rx_fe_ff <= 1'b0;
      rxd_prev_ff <= 1'b1;
    end else begin
      rxd_prev_ff <= rxd;
      rx_st_ff <= nxt_rx_st;
      if (rx_state_chg && rx_st_ff != ast_pkg::AST_DATA &&
          nxt_rx_st != ast_pkg::AST_END)
        rx_os_ff <= 4'h0; // realign at edge and at lead centre
      else if (os_tick) rx_os_ff <= rx_os_ff + 4'h1;
      if (rx_state_chg) rx_cnt_ff <= 4'h0;
      else if (rx_samp) rx_cnt_ff <= rx_cnt_ff + 4'h1;
      if (rx_st_ff == ast_pkg::AST_IDLE) rx_fe_ff <= 1'b0;
      if (rx_samp) begin
        case (rx_st_ff)
          ast_pkg::AST_DATA: rx_sh_ff[rx_cnt_ff] <= rxd;
          ast_pkg::AST_CHK: rx_pbit_ff <= rxd;
          ast_pkg::AST_END:
            if (!rxd) rx_fe_ff <= 1'b1; // [RULE_14]
          default: rx_pbit_ff <= rx_pbit_ff;
        endcase
      end
    end
  end

  wire [8:0] rx_data = rx_sh_ff & len_mask;
  wire frm_now = rx_fe_ff || !rxd; // [RULE_14]
  // odd total counts one extra one
  wire par_now = pen && ((^rx_data ^ rx_pbit_ff) != !peven); // [RULE_15]
  wire ovr_now = rx_full_ff && !rd_rxb; // [RULE_11]
  wire rx_reinit = !rx_en_ff || (rx_en_ff && !nxt_rx_en); // [RULE_20]
  // a receive disable wipes buffer and flags; holding it low keeps
  // them clear, which is how software reinitialises the buffer

  always_ff @(posedge clk) begin
    if (!rst_n || rx_reinit) begin // [RULE_20]
      rxbuf_ff <= 9'h000;
      rx_full_ff <= 1'b0;
      ovr_ff <= 1'b0; // [RULE_18]
      frm_ff <= 1'b0; // [RULE_18]
      par_ff <= 1'b0;
      rx_req_ff <= 1'b0;
    end else begin
      rx_req_ff <= 1'b0;
      if (rx_done) begin
        rxbuf_ff <= rx_data; // [RULE_12]
        rx_full_ff <= 1'b1;
        // no new request on overrun
        rx_req_ff <= !ovr_now; // [RULE_13]
      end else if (rd_rxb) begin
        rx_full_ff <= 1'b0;
      end
      // errors load as the character enters the buffer
      if (rx_done && ovr_now) ovr_ff <= 1'b1; // [RULE_11]
      else if (mode_off_wr) ovr_ff <= 1'b0; // [RULE_18]
      if (rx_done && frm_now) frm_ff <= 1'b1; // [RULE_16]
      else if (mode_off_wr) frm_ff <= 1'b0; // [RULE_18]
      if (rx_done && par_now) par_ff <= 1'b1; // [RULE_16]
      else if (rd_rxb) par_ff <= 1'b0; // [RULE_19]
    end
  end

  wire err_sum = ovr_ff | frm_ff | par_ff; // [RULE_17]

  // unmapped addresses read zero and writes to them are dropped
  // read mux; flags share the word with the character
  wire [15:0] rxb_word = {err_sum, par_ff, frm_ff, ovr_ff,
                          3'b000, rxbuf_ff}; // [RULE_21]
  wire tx_busy = tx_st_ff != ast_pkg::AST_IDLE;
  wire rx_busy = rx_st_ff != ast_pkg::AST_IDLE;
  wire [15:0] stat_word = {12'h000, rx_busy, rx_full_ff,
                           !tx_busy, !tx_full_ff};
  logic [15:0] rd_mux;
  always_comb begin
    case (reg_addr)
      `AST_OFF_MODE: rd_mux = {9'h000, mode_ff};
      `AST_OFF_BAUD: rd_mux = {8'h00, baud_ff};
      `AST_OFF_CTRL: rd_mux = {10'h000, rx_en_ff, tx_en_ff,
                               2'b00, src_ff};
      `AST_OFF_TXBUF: rd_mux = {7'h00, txbuf_ff};
      `AST_OFF_RXBUF: rd_mux = rxb_word;
      `AST_OFF_STAT: rd_mux = stat_word;
      default: rd_mux = 16'h0000;
    endcase
  end
  always_ff @(posedge clk) begin
    if (!rst_n) rdata_ff <= 16'h0000;
    else rdata_ff <= reg_rd ? rd_mux : 16'h0000;
  end

  // full duplex: nothing above couples the two paths
  assign txd = txd_ff; // [RULE_01]
  assign reg_rdata = rdata_ff;
  assign rx_req = rx_req_ff;
  assign tx_empty = !tx_full_ff;
endmodule
`default_nettype wire

// ===== tb/ast_uart_chk.sv
`timescale 1ns/1ps
`default_nettype none
`include "ast_map.svh"
module ast_uart_chk (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_rdata,
  // line and events
  input wire logic rxd,
  input wire logic txd,
  input wire logic ext_clk,
  input wire logic rx_req,
  input wire logic tx_empty
);
  logic [1:0] len_ff;
  logic rxen_ff;
  logic txen_ff;
  logic unread_ff;
  wire logic rxbuf_rd = reg_rd && reg_addr == `AST_OFF_RXBUF;
  wire logic mode_wr = reg_wr && reg_addr == `AST_OFF_MODE;
  wire logic ctrl_wr = reg_wr && reg_addr == `AST_OFF_CTRL;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      len_ff <= 2'h0;
      rxen_ff <= 1'b0;
      txen_ff <= 1'b0;
      unread_ff <= 1'b0;
    end else begin
      if (mode_wr) len_ff <= reg_wdata[1:0];
      if (ctrl_wr) rxen_ff <= reg_wdata[5];
      if (ctrl_wr) txen_ff <= reg_wdata[4];
      // only a read or a receive disable empties the buffer
      unread_ff <= (rxbuf_rd || (ctrl_wr && !reg_wdata[5])) ? 1'b0 :
        (rx_req || unread_ff);
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  lead_min_a: assert property ($fell(txd) |=> !txd [*8])
    else $error("lead bit shorter than nine cycles");
  tx_enabled_a: assert property ($fell(txd) |-> txen_ff && len_ff != 2'h0)
    else $error("frame started while transmit disabled");
  rdata_idle_a: assert property (!reg_rd |=> reg_rdata == 16'h0000)
    else $error("read data not zero outside read answer");
  err_sum_a: assert property (rxbuf_rd |=> reg_rdata[15] == |reg_rdata[14:12])
    else $error("error sum differs from flag or");
  par_clear_a: assert property (rxbuf_rd ##2 rxbuf_rd |=> !reg_rdata[14])
    else $error("parity flag survived buffer read");
  no_ovr_req_a: assert property (rx_req |-> !unread_ff)
    else $error("receive request on overrun");
  req_enabled_a: assert property (rx_req |-> rxen_ff && len_ff != 2'h0)
    else $error("receive request while receiver off");
  req_gap_a: assert property (rx_req |=> !rx_req [*8])
    else $error("receive requests too close");
endmodule
bind ast_uart ast_uart_chk u_ast_uart_chk (
  .clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
  .rxd, .txd, .ext_clk, .rx_req, .tx_empty
);
`default_nettype wire

// ===== tb/ast_peer.sv
`timescale 1ns/1ps
`default_nettype none
module ast_peer (
  // clock
  input wire logic clk,
  // serial lines seen from the far end
  input wire logic txd,
  output logic rxd,
  // frame shape
  input wire logic [15:0] bit_clks,
  input wire logic [3:0] flen
);
  logic [12:0] got;
  initial rxd = 1'b1;
  function automatic logic [12:0] frame(input logic [8:0] d,
    input logic [15:0] m);
    int nb;
    nb = m[1:0] + 6;
    frame = '1;
    frame[0] = 1'b0;
    for (int k = 0; k < nb; k++) frame[1 + k] = d[k];
    if (m[6]) frame[1 + nb] = ^(d & ~(9'h1FF << nb)) ^ !m[5];
  endfunction
  // a bad end bit gets one extra idle bit so the line ends high
  task automatic send(input logic [8:0] d, input logic [15:0] m,
    input logic bad_par, input logic bad_stop);
    logic [12:0] f;
    int n;
    f = frame(d, m);
    n = m[1:0] + 6;
    if (bad_par) f[1 + n] = !f[1 + n];
    if (bad_stop) f[1 + n + m[6]] = 1'b0;
    for (int k = 0; k < 2 + n + m[6] + m[4] + bad_stop; k++) begin
      rxd <= f[k];
      repeat (bit_clks) @(posedge clk);
    end
  endtask
  always begin
    @(negedge txd);
    got = '1;
    repeat (bit_clks / 2) @(posedge clk);
    for (int k = 0; k < flen; k++) begin
      got[k] = txd;
      if (k < flen - 1) repeat (bit_clks) @(posedge clk);
    end
  end
endmodule
`default_nettype wire

// ===== tb/ast_uart_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "ast_map.svh"
module ast_uart_tb;
  localparam logic [15:0] FM [4] = '{16'h0061, 16'h0012, 16'h0053, 16'h0042};
  localparam logic [15:0] FD [4] = '{16'h01A5, 16'h003C, 16'h0155, 16'h0080};
  localparam logic [15:0] RB [5] = '{16'h0000, 16'h0002, 16'h0000, 16'h0000,
    16'h0000};
  localparam logic [15:0] RC [5] = '{16'h0030, 16'h0030, 16'h0031, 16'h0032,
    16'h0033};
  localparam logic [15:0] RM [5] = '{16'h0012, 16'h0002, 16'h0002, 16'h0002,
    16'h0002};
  localparam int RW [5] = '{16, 48, 128, 512, 64};
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [15:0] reg_wdata = 16'h0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic ext_clk = 1'b0;
  logic [15:0] bitc = 16'h0010;
  logic [3:0] flen = 4'hd;
  logic [15:0] reg_rdata;
  logic rxd;
  logic txd;
  logic rx_req;
  logic tx_empty;
  logic [15:0] v;
  logic [15:0] m;
  logic [15:0] d;
  int errors = 0;
  int checks_done = 0;
  int nreq = 0;
  int cyc = 0;
  int q;
  int w;
  ast_uart u_ast_uart (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .rxd(rxd), .txd(txd), .ext_clk(ext_clk),
    .rx_req(rx_req), .tx_empty(tx_empty));
  ast_peer u_ast_peer (.clk(clk), .txd(txd), .rxd(rxd), .bit_clks(bitc),
    .flen(flen));
  always #12.5 clk = ~clk;
  // external source: one rising edge every four main clocks
  always begin
    repeat (2) @(posedge clk);
    ext_clk <= ~ext_clk;
  end
  task automatic give_verdict;
    if (errors == 0 && checks_done > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (rx_req === 1'b1) nreq <= nreq + 1;
    if (cyc == 40000) begin
      errors++;
      give_verdict();
    end
  end
  task automatic chk(input string what, input logic [15:0] exp,
    input logic [15:0] got);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] dat);
    reg_addr <= a;
    reg_wdata <= dat;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [7:0] a, output logic [15:0] dat);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 dat = reg_rdata;
    @(posedge clk);
  endtask
  task automatic hi_width(output int n);
    n = 0;
    while (txd !== 1'b0) @(posedge clk);
    while (txd !== 1'b1) @(posedge clk);
    while (txd === 1'b1) begin
      n++;
      @(posedge clk);
    end
  endtask
  initial begin
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rd(`AST_OFF_CTRL, v);
    chk("ctrl reset", 16'h0000, v);
    rd(`AST_OFF_STAT, v);
    chk("stat reset", 16'h0003, v);
    chk("tx empty", 16'h0001, 16'(tx_empty));
    wr(8'h20, 16'hFFFF);
    rd(8'h20, v);
    chk("unmapped", 16'h0000, v);
    wr(`AST_OFF_BAUD, 16'h0000);
    wr(`AST_OFF_CTRL, 16'h0030);
    for (int i = 0; i < 4; i++) begin
      m = FM[i];
      d = FD[i];
      wr(`AST_OFF_MODE, m);
      flen <= 4'(8 + m[1:0] + m[6] + m[4]);
      q = nreq;
      fork
        u_ast_peer.send(d[8:0], m, 1'b0, 1'b0);
        wr(`AST_OFF_TXBUF, d);
      join
      repeat (32) @(posedge clk);
      chk("tx frame", 16'(u_ast_peer.frame(d[8:0], m)), 16'(u_ast_peer.got));
      chk("rx count", 16'(q + 1), 16'(nreq));
      rd(`AST_OFF_RXBUF, v);
      chk("rx word", 16'(d[8:0] & ~(9'h1FF << (m[1:0] + 6))), v);
    end
    wr(`AST_OFF_MODE, 16'h0062);
    u_ast_peer.send(9'h05A, 16'h0062, 1'b1, 1'b0);
    rd(`AST_OFF_RXBUF, v);
    chk("parity set", 16'hC05A, v);
    rd(`AST_OFF_RXBUF, v);
    chk("parity read", 16'h005A, v);
    u_ast_peer.send(9'h033, 16'h0062, 1'b0, 1'b1);
    rd(`AST_OFF_RXBUF, v);
    chk("framing", 16'hA033, v);
    wr(`AST_OFF_CTRL, 16'h0010);
    wr(`AST_OFF_CTRL, 16'h0030);
    rd(`AST_OFF_RXBUF, v);
    chk("reinit", 16'h0000, v);
    q = nreq;
    u_ast_peer.send(9'h011, 16'h0062, 1'b0, 1'b0);
    u_ast_peer.send(9'h022, 16'h0062, 1'b0, 1'b0);
    chk("overrun count", 16'(q + 1), 16'(nreq));
    rd(`AST_OFF_RXBUF, v);
    chk("overrun", 16'h9022, v);
    wr(`AST_OFF_MODE, 16'h0000);
    rd(`AST_OFF_RXBUF, v);
    chk("mode off flags", 16'h0000, v & 16'hF000);
    for (int i = 0; i < 5; i++) begin
      wr(`AST_OFF_BAUD, RB[i]);
      wr(`AST_OFF_CTRL, RC[i]);
      wr(`AST_OFF_MODE, RM[i]);
      bitc <= 16'(RW[i]);
      wr(`AST_OFF_TXBUF, 16'h00FF);
      while (tx_empty !== 1'b1) @(posedge clk);
      wr(`AST_OFF_TXBUF, 16'h00FF);
      hi_width(w);
      // the transmitter idles one cycle before the queued frame starts
      chk("high run", 16'(RW[i] * (9 + RM[i][4]) + 1), 16'(w));
      repeat (12 * RW[i]) @(posedge clk);
    end
    give_verdict();
  end
endmodule
`default_nettype wire
